/* logic/handler_io_params.svh */
// timing and width constants for the handler i/o block
`ifndef HANDLER_IO_PARAMS_SVH
`define HANDLER_IO_PARAMS_SVH
`define CLK_FREQ_HZ 40000000
`define TRIG_DELAY_NS 10000
`define TRIG_DELAY_CYC ((`TRIG_DELAY_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
`define BIN_DELAY_US 200
`define BIN_DELAY_CYC (`BIN_DELAY_US * (`CLK_FREQ_HZ / 1000000))
`define BIN_COUNT 9
`endif

/* logic/handler_io_pkg.sv */
// types shared by the handler i/o block
`default_nettype none
package handler_io_pkg;
  typedef struct packed {
    logic [3:0] bin_index;
    logic primary_high;
    logic primary_low;
    logic secondary_fail;
  } sort_result_t;
  typedef struct packed {
    logic [8:0] bin_n;
    logic secondary_over_fail_n;
    logic primary_over_fail_n;
    logic primary_high_fail_n;
    logic primary_low_fail_n;
    logic overall_fail_n;
  } sort_pins_t;
endpackage
`default_nettype wire

/* logic/pin_sync.sv */
// two-stage synchroniser for asynchronous pin levels
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1)
  begin
    $error("pin_sync: width must be at least one");
  end
  logic [WIDTH-1:0] stage1;
  // both stages reset high: a trigger already high at reset then gives no edge,
  // and a lock pin idling high reads as unlocked
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= '1;
      sync_out <= '1;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

/* logic/handler_io.sv */
// handler interface: sorting outputs, status flags and trigger input
//
// Summary of operation
// - Nine active-low bin outputs; only the bin holding the sort result is driven low.
// - Secondary over-fail goes low on a secondary fail, only while aux comparison is on.
// - Primary over-fail is low when primary high-fail or low-fail is asserted.
// - Primary high-fail goes low when the primary value exceeds its upper limit.
// - Primary low-fail goes low when the primary value is below its lower limit.
// - Overall fail is low when primary or secondary over-fail is asserted.
// - Conversion flag is low while the a/d conversion runs and high when it ends.
// - Measure-done is low while the test runs and high once it completes.
// - A rising edge on the external trigger starts a measurement.
// - Keypad is locked while the lock input is low, unlocked while it is high.
// - The measurement starts less than 10 us after a valid trigger edge.
// - Sort outputs appear 200 us after the digital computation completes.
`default_nettype none
`include "handler_io_params.svh"
module handler_io #(
  parameter int BIN_DELAY_CYCLES = `BIN_DELAY_CYC,
  parameter int TRIG_DELAY_CYCLES = `TRIG_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic external_trigger_in,
  input wire logic keypad_lock_in_n,
  input wire logic aux_compare_on,
  input wire logic conversion_done,
  input wire logic compute_done,
  input wire handler_io_pkg::sort_result_t result,
  output logic measure_start,
  output logic keypad_locked,
  output logic conversion_busy_n,
  output logic measure_done_n,
  output handler_io_pkg::sort_pins_t pins
);
  // --------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------
  // start leaves 3 cycles after the pin edge, so a bound of 3 or less is unreachable
  if (TRIG_DELAY_CYCLES <= 3)
  begin
    $error("handler_io: trigger bound must exceed the 3-cycle start latency");
  end
  // settle_count is 32 bits wide, so any positive delay fits
  if (BIN_DELAY_CYCLES < 1)
  begin
    $error("handler_io: bin delay must be at least one cycle");
  end
  // the pin struct is laid out for exactly nine bins
  if (`BIN_COUNT != 9)
  begin
    $error("handler_io: bin count must match the pin struct");
  end

  typedef enum logic [1:0] {idle_s, convert_s, compute_s, settle_s} state_t;
  state_t state;
  logic [1:0] sync_pins;
  logic trig_prev;
  logic trig_rise;
  logic [31:0] settle_count;
  handler_io_pkg::sort_result_t held;
  logic p_over;
  logic s_over;

  // --------------------------------------------------------------
  // bin decode
  // --------------------------------------------------------------
  // active-low one-of-nine; codes outside 1..9 leave every bin high
  function automatic logic [8:0] bin_decode(input logic [3:0] index);
    logic [8:0] lines;
    lines = 9'h1FF;
    for (int b = 0; b < `BIN_COUNT; b++)
    begin
      if (32'(index) == 32'(b + 1))
        lines[b] = 1'b0;
    end
    return lines;
  endfunction

  // fail terms of the held result; secondary only counts with aux comparison on
  assign p_over = held.primary_high | held.primary_low;
  assign s_over = held.secondary_fail & aux_compare_on;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  // a trigger pulse shorter than one clock period may be missed; the two flops
  // cost two cycles of start latency, well inside the trigger bound
  pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({external_trigger_in, keypad_lock_in_n}),
    .sync_out(sync_pins)
  );

  // --------------------------------------------------------------
  // edge detection and keypad lock
  // --------------------------------------------------------------
  // trig_prev starts high so a trigger held high at reset is no edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      trig_prev <= 1'b1;
    else
      trig_prev <= sync_pins[1];
  end
  assign trig_rise = sync_pins[1] & ~trig_prev;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      keypad_locked <= 1'b0;
    else
      keypad_locked <= ~sync_pins[0];
  end

  // --------------------------------------------------------------
  // measurement sequence
  // --------------------------------------------------------------
  // start is issued 3 cycles after the pin edge: well under 10 us at 40 MHz
  // compute_done is taken only in compute_s; an earlier pulse is lost
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= idle_s;
      measure_start <= 1'b0;
      settle_count <= 32'h0;
      held <= '0;
    end
    else
    begin
      measure_start <= 1'b0;
      case (state)
        idle_s:
        begin
          // back-to-back triggers are fine once idle is reached
          if (trig_rise)
          begin
            measure_start <= 1'b1;
            state <= convert_s;
          end
        end
        convert_s:
        begin
          if (conversion_done)
            state <= compute_s;
        end
        compute_s:
        begin
          if (compute_done)
          begin
            held <= result;
            settle_count <= 32'(BIN_DELAY_CYCLES - 1);
            state <= settle_s;
          end
        end
        settle_s:
        begin
          if (settle_count == 32'h0)
            state <= idle_s;
          else
            settle_count <= settle_count - 32'h1;
        end
        default: state <= idle_s;
      endcase
      // edges outside idle_s fall through unused
    end
  end

  // --------------------------------------------------------------
  // status and sort outputs
  // --------------------------------------------------------------
  // the counter is loaded with delay-1, so the pins change BIN_DELAY_CYCLES
  // edges after compute_done is taken
  logic publish;
  assign publish = (state == settle_s) && (settle_count == 32'h0);

  // busy falls with the start pulse and rises on the edge after conversion_done;
  // a conversion_done outside convert_s has no effect
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      conversion_busy_n <= 1'b1;
    else
      conversion_busy_n <= ~(trig_rise && state == idle_s)
        && !(state == convert_s && !conversion_done);
  end

  // done rises one cycle after the sort pins change
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      measure_done_n <= 1'b1;
    else if (state == idle_s && trig_rise)
      measure_done_n <= 1'b0;
    else if (state == idle_s)
      measure_done_n <= 1'b1;
  end

  // --------------------------------------------------------------
  // sort outputs
  // --------------------------------------------------------------
  // the pins keep the last result between measurements, so a slow handler
  // may read them at any time after done rises
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pins <= '1;
    else if (publish)
    begin
      pins.bin_n <= bin_decode(held.bin_index);
      pins.primary_high_fail_n <= ~held.primary_high;
      pins.primary_low_fail_n <= ~held.primary_low;
      pins.primary_over_fail_n <= ~p_over;
      pins.secondary_over_fail_n <= ~s_over;
      pins.overall_fail_n <= ~(p_over | s_over);
    end
  end
endmodule
`default_nettype wire

/* verif/handler_io_sva.sv */
// port assertions for the handler i/o block
`default_nettype none
module handler_io_sva #(
  parameter int BIN_DELAY_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic external_trigger_in,
  input wire logic keypad_lock_in_n,
  input wire logic aux_compare_on,
  input wire logic conversion_done,
  input wire logic compute_done,
  input wire handler_io_pkg::sort_result_t result,
  input wire logic measure_start,
  input wire logic keypad_locked,
  input wire logic conversion_busy_n,
  input wire logic measure_done_n,
  input wire handler_io_pkg::sort_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  handler_io_pkg::sort_result_t res;
  int unsigned since;
  logic [9:0] hot;
  // a counter rather than a delay, since the real bin delay is thousands of cycles
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      since <= 0;
    else
      since <= compute_done ? 1 : since + 1;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      res <= '0;
    else if (compute_done)
      res <= result;
  assign hot = 10'h001 << res.bin_index;
  trig_start_a:
    assert property ($rose(external_trigger_in) && measure_done_n |-> ##3 measure_start)
    else $error("no start after trigger");
  conv_end_a:
    assert property (conversion_done && !conversion_busy_n |=> conversion_busy_n)
    else $error("busy flag stuck");
  // pins move BIN_DELAY_CYCLES edges after the take, done one edge later,
  // and the rise is sampled one edge after that
  bin_delay_a:
    assert property ($rose(measure_done_n) |-> since == BIN_DELAY_CYCLES + 2)
    else $error("bin delay wrong");
  bin_select_a:
    assert property ($rose(measure_done_n) |-> pins.bin_n == ~hot[9:1])
    else $error("bin outputs wrong");
  primary_fail_a:
    assert property ($rose(measure_done_n) |-> {pins.primary_high_fail_n,
      pins.primary_low_fail_n} == ~{res.primary_high, res.primary_low})
    else $error("primary fail wrong");
  secondary_fail_a:
    assert property ($rose(measure_done_n) |->
      pins.secondary_over_fail_n == !(res.secondary_fail && aux_compare_on))
    else $error("secondary fail wrong");
  primary_over_a:
    assert property (pins.primary_over_fail_n ==
      (pins.primary_high_fail_n && pins.primary_low_fail_n))
    else $error("primary over wrong");
  overall_fail_a:
    assert property (pins.overall_fail_n ==
      (pins.primary_over_fail_n && pins.secondary_over_fail_n))
    else $error("overall fail wrong");
  keypad_lock_a:
    assert property (!keypad_lock_in_n [*4] |-> keypad_locked)
    else $error("keypad not locked");
  keypad_unlock_a:
    assert property (keypad_lock_in_n [*4] |-> !keypad_locked)
    else $error("keypad not unlocked");
  pins_hold_a:
    assert property (measure_done_n && $past(measure_done_n) |-> $stable(pins))
    else $error("pins moved while idle");
endmodule
bind handler_io handler_io_sva #(.BIN_DELAY_CYCLES(BIN_DELAY_CYCLES)) u_sva (.clk, .rst_b,
  .external_trigger_in, .keypad_lock_in_n, .aux_compare_on, .conversion_done,
  .compute_done, .result, .measure_start, .keypad_locked, .conversion_busy_n,
  .measure_done_n, .pins);
`default_nettype wire

/* verif/handler_model.sv */
// handler side: turns a fire request into a trigger pulse
`default_nettype none
module handler_model (
  input wire logic clk,
  input wire logic fire,
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left = 4'h0;
  // pulse held several cycles so the synchroniser cannot miss it
  always_ff @(posedge clk)
    if (fire)
      left <= 4'h3;
    else if (left != 4'h0)
      left <= left - 4'h1;
  assign trig = (left != 4'h0);
endmodule
`default_nettype wire

/* verif/component_sorter_handler_io_bench.sv */
// self-checking bench for the handler i/o block
`default_nettype none
module component_sorter_handler_io_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BD = 4;
  logic clk = 0, rst_b = 0, fire = 0, trig, lock_n = 1, aux = 0, conv = 0, comp = 0;
  logic start, locked, busy_n, done_n, f, s;
  logic [8:0] bin;
  handler_io_pkg::sort_result_t res = '0;
  handler_io_pkg::sort_pins_t pins, exp_q[$];
  int n_errors = 0, compares = 0, seed = 99, cyc = 0, k, hits;
  always #12.5 clk = ~clk;
  handler_model PARTNER (.clk(clk), .fire(fire), .trig(trig));
  handler_io #(.BIN_DELAY_CYCLES(BD)) DUT (.clk(clk), .rst_b(rst_b), .external_trigger_in(trig),
    .keypad_lock_in_n(lock_n), .aux_compare_on(aux), .conversion_done(conv),
    .compute_done(comp), .result(res), .measure_start(start), .keypad_locked(locked),
    .conversion_busy_n(busy_n), .measure_done_n(done_n), .pins(pins));
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
    // bin index walks 0..15 so every bin and the out-of-range codes are seen
    for (int i = 0; i < 16; i++)
    begin
      res <= {4'(i), 3'($random(seed))};
      aux <= 1'($random(seed));
      lock_n <= 1'($random(seed));
      fire <= 1;
      @(posedge clk);
      fire <= 0;
      for (k = 0; k < 20 && start !== 1'b1; k++) @(posedge clk);
      chk(14'({start, busy_n, done_n}), 14'h4);
      repeat (2) @(posedge clk);
      fire <= 1;
      @(posedge clk);
      fire <= 0;
      hits = 0;
      repeat (6 + i % 4)
      begin
        @(posedge clk);
        hits += (start !== 1'b0);
      end
      chk(14'(hits), 14'h0);
      conv <= 1;
      @(posedge clk);
      conv <= 0;
      @(posedge clk);
      chk(14'({busy_n, done_n}), 14'h2);
      f = res.primary_high | res.primary_low;
      s = res.secondary_fail & aux;
      bin = (i >= 1 && i <= 9) ? 9'(~(9'h001 << (i - 1))) : 9'h1FF;
      exp_q.push_back({bin, !s, !f, !res.primary_high, !res.primary_low, !(f | s)});
      comp <= 1;
      @(posedge clk);
      comp <= 0;
      for (k = 0; k < 50 && done_n !== 1'b1; k++) @(posedge clk);
      // pins at take+BD, done at take+BD+1, seen high at the edge after
      chk(14'(k), 14'(BD + 2));
      chk(pins, exp_q.pop_front());
      chk(14'(locked), 14'(!lock_n));
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
